// ==== src/conditioner_pkg.sv ====
// Purpose: Shared constants and types of the channel value conditioner
// Assumes: APB with 32-bit data, byte addresses, one word per register
// Notes: Percent values are signed Q2.14, 16'h4000 stands for 100 percent
package conditioner_pkg;
  localparam int NUM_CH = 4;
  localparam int PCT_SHIFT = 14;
  localparam logic signed [15:0] PCT_FULL = 16'sh4000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FCNT = 8'h04;
  localparam logic [7:0] OFS_LOWER = 8'h08;
  localparam logic [7:0] OFS_START = 8'h0C;
  localparam logic [7:0] OFS_END = 8'h10;
  localparam logic [7:0] OFS_UPPER = 8'h14;
  localparam logic [7:0] OFS_SIM = 8'h18;
  localparam logic [7:0] OFS_SUBST = 8'h1C;
  localparam logic [7:0] OFS_EXTCJC = 8'h20;
  localparam logic [7:0] OFS_CHAN0 = 8'h24;
  localparam logic [7:0] OFS_CHAN_END = 8'h34;

  // Control word fields
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_MON = 1;
  localparam int CTRL_CJC = 2;
  localparam int CTRL_SIMINV = 3;
  localparam int CTRL_SIM = 4;
  localparam int CTRL_EMODE = 8;

  // Channel word layout
  localparam int STATUS_W = 4;
  localparam int FAULT_BIT = 1;

  // Scaling span inside which status bits are carried
  localparam logic [15:0] SPAN_MIN = 16'h2710;
  localparam logic [15:0] SPAN_MAX = 16'hC350;

  // Reset values
  localparam logic RST_ACTIVE = 1'b0;
  localparam logic [7:0] FCNT_RST = 8'h0A;
  localparam logic [7:0] CNT_RST = 8'hFF;
  localparam logic [15:0] LOWER_RST = 16'h0000;
  localparam logic [15:0] START_RST = SPAN_MIN;
  localparam logic [15:0] END_RST = SPAN_MAX;
  localparam logic [15:0] UPPER_RST = 16'hEA60;
  localparam logic [15:0] PCT_RST = 16'h0000;

  typedef enum logic [1:0] {
    ERR_CURRENT = 2'b00,
    ERR_SUBST = 2'b01,
    ERR_HOLD = 2'b11
  } err_mode_t;
endpackage

// ==== src/point_scaler.sv ====
// Purpose: Map a percent value onto points and clamp it to the limits
// Assumes: Start and end are unsigned points, percent is signed Q2.14
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
module point_scaler
  import conditioner_pkg::*;
(
  input logic signed [15:0] pct,
  input logic [15:0] lower,
  input logic [15:0] start,
  input logic [15:0] stop,
  input logic [15:0] upper,
  output logic [15:0] points
);
  logic signed [17:0] span;
  logic signed [33:0] prod;
  logic signed [19:0] raw;

  always_comb begin
    span = $signed({2'b00, stop}) - $signed({2'b00, start});
    prod = pct * span;
    raw = $signed({4'h0, start}) + 20'(prod >>> PCT_SHIFT);
    // Lower limit checked first, so a crossed pair yields the lower limit only for raw values below it, else the upper limit
    if (raw < $signed({4'h0, lower})) begin
      points = lower;
    end else if (raw > $signed({4'h0, upper})) begin
      points = upper;
    end else begin
      points = raw[15:0];
    end
  end
endmodule

// ==== src/analog_channel_value_conditioner.sv ====
// Purpose: Per-channel value conditioning of a four-channel thermocouple input
// Assumes: One measurement strobe per channel per measuring cycle, same clock
// Notes: Channel words go out one per strobe while active, one cycle after the strobe
//
// What this block does
// - Normal mode forwards compensated field value
// - Simulation mode forwards configured simulation value
// - Current-value strategy forwards field value despite fault
// - Substitute strategy forwards configured substitute on fault
// - Fault replacement values carry invalid-data flag
// - Hold strategy forwards last valid value
// - Good again only after clean cycle count
// - Lower limit is smallest output value
// - Range start maps zero percent
// - Range end maps hundred percent
// - Upper limit is largest output value
// - Channels follow the module-wide active setting
// - Internal or external cold junction selectable
// - External junction uses configured reference temperature
// - Word low four bits status, bit one fault
// - Status omitted when scaling leaves span
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module analog_channel_value_conditioner
  import conditioner_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic meas_valid,
  input logic [1:0] meas_chan,
  input logic signed [15:0] meas_value,
  input logic meas_fault,
  input logic signed [15:0] int_cjc_temp,
  output logic out_valid,
  output logic [1:0] out_chan,
  output logic [15:0] out_word,
  output logic out_invalid
);
  // Configuration registers
  logic active_q, active_d;
  logic mon_q, mon_d;
  logic cjc_ext_q, cjc_ext_d;
  logic sim_inv_q, sim_inv_d;
  logic [NUM_CH-1:0] sim_en_q, sim_en_d;
  logic [NUM_CH-1:0][1:0] emode_q, emode_d;
  logic [7:0] fcnt_q, fcnt_d;
  logic [15:0] lower_q, lower_d;
  logic [15:0] start_q, start_d;
  logic [15:0] end_q, end_d;
  logic [15:0] upper_q, upper_d;
  logic signed [15:0] sim_pct_q, sim_pct_d;
  logic signed [15:0] subst_pct_q, subst_pct_d;
  logic signed [15:0] ext_cjc_q, ext_cjc_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] ctrl_rd;

  // Channel state
  logic [NUM_CH-1:0][7:0] cnt_q, cnt_d;
  logic [NUM_CH-1:0][15:0] last_q, last_d;
  logic [NUM_CH-1:0][15:0] word_q, word_d;
  logic [NUM_CH-1:0] inv_q, inv_d;
  logic [NUM_CH-1:0] bad_q, bad_d;
  logic out_valid_q, out_valid_d;
  logic [1:0] out_chan_q, out_chan_d;
  logic [15:0] out_word_q, out_word_d;
  logic out_invalid_q, out_invalid_d;

  logic signed [15:0] cold_junction_compensation;
  logic signed [15:0] field_pct;
  logic signed [15:0] sel_pct;
  logic sel_inv;
  logic fault_now;
  logic bad_now;
  logic [7:0] cnt_n;
  logic status_on;
  logic [STATUS_W-1:0] stat;
  logic [15:0] points;

  function automatic logic in_chan_window(input logic [7:0] a);
    return (a >= OFS_CHAN0) && (a < OFS_CHAN_END) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [1:0] chan_of(input logic [7:0] a);
    return 2'(a[7:2] - OFS_CHAN0[7:2]);
  endfunction

  assign ctrl_rd = {16'h0000, emode_q, sim_en_q, sim_inv_q, cjc_ext_q, mon_q, active_q};

  // Register bus: one wait state, answer registered
  always_comb begin
    active_d = active_q;
    mon_d = mon_q;
    cjc_ext_d = cjc_ext_q;
    sim_inv_d = sim_inv_q;
    sim_en_d = sim_en_q;
    emode_d = emode_q;
    fcnt_d = fcnt_q;
    lower_d = lower_q;
    start_d = start_q;
    end_d = end_q;
    upper_d = upper_q;
    sim_pct_d = sim_pct_q;
    subst_pct_d = subst_pct_q;
    ext_cjc_d = ext_cjc_q;
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    pready_d = psel & penable & ~pready_q;
    if (pready_d) begin
      unique case (paddr)
        OFS_CTRL: begin
          prdata_d = ctrl_rd;
          if (pwrite) begin
            active_d = pwdata[CTRL_ACTIVE];
            mon_d = pwdata[CTRL_MON];
            cjc_ext_d = pwdata[CTRL_CJC];
            sim_inv_d = pwdata[CTRL_SIMINV];
            sim_en_d = pwdata[CTRL_SIM +: NUM_CH];
            emode_d = pwdata[CTRL_EMODE +: 2*NUM_CH];
          end
        end
        OFS_FCNT: begin
          prdata_d = {24'h00_0000, fcnt_q};
          if (pwrite) begin
            fcnt_d = pwdata[7:0];
          end
        end
        OFS_LOWER: begin
          prdata_d = {16'h0000, lower_q};
          if (pwrite) begin
            lower_d = pwdata[15:0];
          end
        end
        OFS_START: begin
          prdata_d = {16'h0000, start_q};
          if (pwrite) begin
            start_d = pwdata[15:0];
          end
        end
        OFS_END: begin
          prdata_d = {16'h0000, end_q};
          if (pwrite) begin
            end_d = pwdata[15:0];
          end
        end
        OFS_UPPER: begin
          prdata_d = {16'h0000, upper_q};
          if (pwrite) begin
            upper_d = pwdata[15:0];
          end
        end
        OFS_SIM: begin
          prdata_d = {16'h0000, sim_pct_q};
          if (pwrite) begin
            sim_pct_d = pwdata[15:0];
          end
        end
        OFS_SUBST: begin
          prdata_d = {16'h0000, subst_pct_q};
          if (pwrite) begin
            subst_pct_d = pwdata[15:0];
          end
        end
        OFS_EXTCJC: begin
          prdata_d = {16'h0000, ext_cjc_q};
          if (pwrite) begin
            ext_cjc_d = pwdata[15:0];
          end
        end
        default: begin
          // Channel words are read-only; writes there are dropped quietly
          if (in_chan_window(paddr)) begin
            prdata_d = {14'h0000, inv_q[chan_of(paddr)], bad_q[chan_of(paddr)],
                        word_q[chan_of(paddr)]};
          end else begin
            pslverr_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= RST_ACTIVE;
      mon_q <= 1'b0;
      cjc_ext_q <= 1'b0;
      sim_inv_q <= 1'b0;
      sim_en_q <= '0;
      emode_q <= {NUM_CH{ERR_CURRENT}};
      fcnt_q <= FCNT_RST;
      lower_q <= LOWER_RST;
      start_q <= START_RST;
      end_q <= END_RST;
      upper_q <= UPPER_RST;
      sim_pct_q <= PCT_RST;
      subst_pct_q <= PCT_RST;
      ext_cjc_q <= PCT_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      active_q <= active_d;
      mon_q <= mon_d;
      cjc_ext_q <= cjc_ext_d;
      sim_inv_q <= sim_inv_d;
      sim_en_q <= sim_en_d;
      emode_q <= emode_d;
      fcnt_q <= fcnt_d;
      lower_q <= lower_d;
      start_q <= start_d;
      end_q <= end_d;
      upper_q <= upper_d;
      sim_pct_q <= sim_pct_d;
      subst_pct_q <= subst_pct_d;
      ext_cjc_q <= ext_cjc_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  point_scaler u_scaler (
    .pct(sel_pct),
    .lower(lower_q),
    .start(start_q),
    .stop(end_q),
    .upper(upper_q),
    .points(points)
  );

  // Measurement path
  always_comb begin
    cnt_d = cnt_q;
    last_d = last_q;
    word_d = word_q;
    inv_d = inv_q;
    bad_d = bad_q;
    out_valid_d = 1'b0;
    out_chan_d = out_chan_q;
    out_word_d = out_word_q;
    out_invalid_d = out_invalid_q;
    cold_junction_compensation = cjc_ext_q ? ext_cjc_q : int_cjc_temp;
    field_pct = meas_value + cold_junction_compensation;
    fault_now = mon_q & meas_fault;
    // The clean measurement that reaches the count is itself reported good
    if (fault_now) begin
      cnt_n = 8'h00;
    end else if (cnt_q[meas_chan] < fcnt_q) begin
      cnt_n = cnt_q[meas_chan] + 8'h01;
    end else begin
      cnt_n = cnt_q[meas_chan];
    end
    bad_now = mon_q & (fault_now | (cnt_n < fcnt_q));
    sel_pct = field_pct;
    sel_inv = 1'b0;
    if (sim_en_q[meas_chan]) begin
      sel_pct = sim_pct_q;
      sel_inv = sim_inv_q;
    end else if (bad_now) begin
      unique case (err_mode_t'(emode_q[meas_chan]))
        ERR_SUBST: begin
          sel_pct = subst_pct_q;
          sel_inv = 1'b1;
        end
        ERR_HOLD: begin
          sel_pct = last_q[meas_chan];
          sel_inv = 1'b1;
        end
        default: begin
          sel_pct = field_pct;
          sel_inv = 1'b0;
        end
      endcase
    end
    status_on = (start_q >= SPAN_MIN) && (end_q <= SPAN_MAX);
    stat = '0;
    stat[FAULT_BIT] = bad_now;
    if (meas_valid && active_q) begin
      cnt_d[meas_chan] = cnt_n;
      if (!bad_now && !sim_en_q[meas_chan]) begin
        last_d[meas_chan] = field_pct;
      end
      out_valid_d = 1'b1;
      out_chan_d = meas_chan;
      out_word_d = status_on ? {points[15:STATUS_W], stat} : points;
      out_invalid_d = sel_inv;
      word_d[meas_chan] = out_word_d;
      inv_d[meas_chan] = sel_inv;
      bad_d[meas_chan] = bad_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {NUM_CH{CNT_RST}};
      last_q <= '0;
      word_q <= '0;
      inv_q <= '0;
      bad_q <= '0;
      out_valid_q <= 1'b0;
      out_chan_q <= 2'h0;
      out_word_q <= 16'h0000;
      out_invalid_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      last_q <= last_d;
      word_q <= word_d;
      inv_q <= inv_d;
      bad_q <= bad_d;
      out_valid_q <= out_valid_d;
      out_chan_q <= out_chan_d;
      out_word_q <= out_word_d;
      out_invalid_q <= out_invalid_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign out_valid = out_valid_q;
  assign out_chan = out_chan_q;
  assign out_word = out_word_q;
  assign out_invalid = out_invalid_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_meas;
    meas_valid && active_q;
  endsequence
  sequence s_field;
    s_meas and !sim_en_q[meas_chan];
  endsequence
  sequence s_fault_mode(err_mode_t m);
    s_field and (bad_now && (emode_q[meas_chan] == m));
  endsequence
  sequence s_in_limits(logic [15:0] v);
    (lower_q <= v) && (v <= upper_q) && (start_q <= end_q);
  endsequence

  property p_run;
    s_meas |=> out_valid_q && (out_chan_q == $past(meas_chan)) ##1 !out_valid_q || $past(meas_valid);
  endproperty
  a_run: assert property (p_run) else $error("Channel word missing after strobe");
  property p_idle;
    meas_valid && !active_q |=> !out_valid_q;
  endproperty
  a_idle: assert property (p_idle) else $error("Inactive module sent a word");
  property p_normal;
    (s_field and !bad_now) |-> (sel_pct == field_pct) && !sel_inv;
  endproperty
  a_normal: assert property (p_normal) else $error("Normal value not forwarded");
  property p_sim;
    (s_meas and sim_en_q[meas_chan]) |=> out_valid_q && (out_invalid_q == $past(sim_inv_q));
  endproperty
  a_sim: assert property (p_sim) else $error("Simulation status wrong");
  property p_current;
    s_fault_mode(ERR_CURRENT) |-> sel_pct == field_pct;
  endproperty
  a_current: assert property (p_current) else $error("Current value altered");
  property p_subst;
    s_fault_mode(ERR_SUBST) |=> out_valid_q && out_invalid_q;
  endproperty
  a_subst: assert property (p_subst) else $error("Substitute lacks invalid flag");
  property p_hold;
    s_fault_mode(ERR_HOLD) |-> (sel_pct == last_q[meas_chan]) && sel_inv;
  endproperty
  a_hold: assert property (p_hold) else $error("Held value not forwarded");
  property p_fault;
    (s_meas and (fault_now && status_on)) |=> out_word_q[FAULT_BIT];
  endproperty
  a_fault: assert property (p_fault) else $error("Wire fault bit not set");
  property p_recover;
    (s_meas and fault_now) |=> (cnt_q[$past(meas_chan)] == 8'h00) && bad_q[$past(meas_chan)];
  endproperty
  a_recover: assert property (p_recover) else $error("Clean count not restarted");
  property p_floor;
    (s_meas and (lower_q <= upper_q)) |-> points >= lower_q;
  endproperty
  a_floor: assert property (p_floor) else $error("Output below lower limit");
  property p_ceiling;
    (s_meas and (lower_q <= upper_q)) |-> points <= upper_q;
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("Output above upper limit");
  property p_start;
    (s_meas and (sel_pct == 16'sh0000) and s_in_limits(start_q)) |-> points == start_q;
  endproperty
  a_start: assert property (p_start) else $error("Zero percent not at start");
  property p_end;
    (s_meas and (sel_pct == PCT_FULL) and s_in_limits(end_q)) |-> points == end_q;
  endproperty
  a_end: assert property (p_end) else $error("Full scale not at end");
  property p_word;
    (s_meas and status_on) |=> (out_word_q[STATUS_W-1:0] == {2'b00, $past(bad_now), 1'b0});
  endproperty
  a_word: assert property (p_word) else $error("Status nibble wrong");
  property p_plain;
    (s_meas and !status_on) |=> out_word_q == $past(points);
  endproperty
  a_plain: assert property (p_plain) else $error("Status not omitted");
  property p_cjc;
    (s_field and (!bad_now && cjc_ext_q)) |-> sel_pct == 16'(meas_value + ext_cjc_q);
  endproperty
  a_cjc: assert property (p_cjc) else $error("External junction not applied");
endmodule

// ==== dv/comm_unit_model.sv ====
// Purpose: Collects channel words the way the communication unit would
// Assumes: One word per out_valid pulse, sampled at the rising edge
// Notes: Never stalls; the stream has no back-pressure to model
`timescale 1ns/1ps
module comm_unit_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic out_valid,
  input wire logic [1:0] out_chan,
  input wire logic [15:0] out_word,
  input wire logic out_invalid
);
  // Entries are {channel, invalid flag, word}
  logic [18:0] words[$];

  always @(posedge pclk) begin
    if (presetn === 1'b1 && out_valid === 1'b1) begin
      words.push_back({out_chan, out_invalid, out_word});
    end
  end
endmodule

// ==== dv/analog_channel_value_conditioner_bench.sv ====
// Purpose: Self-checking bench of the channel value conditioner
// Assumes: APB answers with one wait state, words one cycle after a strobe
// Notes: Integer model mirrors the registers and per-channel fault state
`timescale 1ns/1ps
module analog_channel_value_conditioner_bench;
  import conditioner_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic meas_valid, meas_fault, out_valid, out_invalid;
  logic [1:0] meas_chan, out_chan;
  logic signed [15:0] meas_value, int_cjc_temp;
  logic [15:0] out_word;
  int miscompares, num_checks;
  int regs[9];
  int cnt[4];
  logic signed [15:0] holdv[4];

  analog_channel_value_conditioner u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid), .meas_chan(meas_chan),
    .meas_value(meas_value), .meas_fault(meas_fault), .int_cjc_temp(int_cjc_temp),
    .out_valid(out_valid), .out_chan(out_chan), .out_word(out_word), .out_invalid(out_invalid));
  comm_unit_model u_comm (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
    .out_chan(out_chan), .out_word(out_word), .out_invalid(out_invalid));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && a <= OFS_EXTCJC && a[1:0] == 2'b00) regs[a >> 2] = d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check("prdata", r, exp);
    check("pslverr", {31'h0000_0000, e}, {31'h0000_0000, experr});
  endtask

  function automatic logic [15:0] scale(input logic signed [15:0] p);
    longint v;
    v = longint'(regs[3]) + ((longint'(p) * (regs[4] - regs[3])) >>> 14);
    if (v < regs[2]) v = regs[2];
    else if (v > regs[5]) v = regs[5];
    return v[15:0];
  endfunction

  task automatic strobe(input int ch, input logic signed [15:0] v, input logic f);
    logic signed [15:0] cj, p;
    logic bad, inv;
    logic [15:0] pts, w;
    int c, md, n0;
    c = regs[0];
    cj = 16'(rnd() & 32'h0000_03FF);
    n0 = u_comm.words.size();
    @(posedge pclk);
    meas_valid <= 1'b1;
    meas_chan <= 2'(ch);
    meas_value <= v;
    meas_fault <= f;
    int_cjc_temp <= cj;
    @(posedge pclk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    if (!c[0]) begin
      check("word count", u_comm.words.size(), n0);
      return;
    end
    p = v + (c[2] ? 16'(regs[8]) : cj);
    if (c[1] && f) cnt[ch] = 0;
    else if (cnt[ch] < 255) cnt[ch]++;
    bad = c[1] && (cnt[ch] < regs[1]);
    md = (c >> (8 + 2 * ch)) & 3;
    inv = 1'b0;
    if (c[4 + ch]) begin
      p = 16'(regs[6]);
      inv = c[3];
    end else if (bad && md == 1) begin
      p = 16'(regs[7]);
      inv = 1'b1;
    end else if (bad && md == 3) begin
      p = holdv[ch];
      inv = 1'b1;
    end else if (!bad) begin
      holdv[ch] = p;
    end
    pts = scale(p);
    w = (regs[3] >= 10000 && regs[4] <= 50000) ? {pts[15:4], 2'b00, bad, 1'b0} : pts;
    check("word count", u_comm.words.size(), n0 + 1);
    check("word", u_comm.words[n0], {2'(ch), inv, w});
    rd_check(OFS_CHAN0 + 8'(4 * ch), {14'h0000, inv, bad, w}, 1'b0);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    seed = 32'h163d_ee8f;
    cnt = '{255, 255, 255, 255};
    holdv = '{default: 16'h0000};
    regs = '{0, FCNT_RST, LOWER_RST, START_RST, END_RST, UPPER_RST, 0, 0, 0};
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    meas_valid = 1'b0;
    meas_chan = 2'b00;
    meas_value = 16'sh0000;
    meas_fault = 1'b0;
    int_cjc_temp = 16'sh0000;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) rd_check(8'(4 * i), regs[i], 1'b0);
    rd_check(8'h40, 32'h0000_0000, 1'b1);
    rd_check(8'h02, 32'h0000_0000, 1'b1);
    wr(OFS_CHAN0, 32'hFFFF_FFFF);
    rd_check(OFS_CHAN0, 32'h0000_0000, 1'b0);
    strobe(0, 16'sh2000, 1'b0);
    wr(OFS_CTRL, 32'h0000_0001);
    strobe(1, -16'sh1000, 1'b0);
    strobe(2, 16'sh5000, 1'b0);
    // Tighter limits so that clamping really bites
    wr(OFS_LOWER, 32'h0000_1388);
    wr(OFS_UPPER, 32'h0000_D6D8);
    for (int i = 0; i < 16; i++) begin
      strobe(i % 4, 16'(rnd() % 32'h0000_6000) - 16'sh1000, 1'(rnd() & 32'h0000_0001));
    end
    wr(OFS_EXTCJC, 32'h0000_0100);
    wr(OFS_CTRL, 32'h0000_0005);
    strobe(0, 16'sh1000, 1'b0);
    strobe(1, 16'sh3C00, 1'b0);
    wr(OFS_SIM, 32'h0000_3000);
    wr(OFS_CTRL, 32'h0000_0049);
    strobe(2, 16'sh0800, 1'b0);
    strobe(1, 16'sh0800, 1'b0);
    wr(OFS_FCNT, 32'h0000_0003);
    wr(OFS_SUBST, 32'h0000_0C00);
    wr(OFS_CTRL, 32'h0000_E403);
    for (int ch = 0; ch < 4; ch++) begin
      strobe(ch, 16'sh2000, 1'b0);
      strobe(ch, 16'sh2400, 1'b1);
      for (int k = 0; k < 3; k++) strobe(ch, 16'sh2800, 1'b0);
    end
    wr(OFS_START, 32'h0000_1388);
    strobe(0, 16'sh2000, 1'b0);
    wr(OFS_START, 32'h0000_2710);
    wr(OFS_END, 32'h0000_D000);
    strobe(3, 16'sh2000, 1'b0);
    wr(OFS_CTRL, 32'h0000_0000);
    strobe(1, 16'sh2000, 1'b0);
    end_of_test();
  end
endmodule
